/* csv_consts.svh */
`ifndef CSV_CONSTS_SVH
`define CSV_CONSTS_SVH

// ----------------------------------------------------------------------
// timing, in nanoseconds and milliseconds
// ----------------------------------------------------------------------
// 4 ns reference clock period
`define CSV_CLK_NS 32'h0000_0004
// 1 ms, the base tick of the detection and safety timers
`define CSV_MS_NS 32'h000f_4240
// 1.6 ms, one soft-start step
`define CSV_SS_STEP_NS 32'h0018_6a00
// 1000 ms discharge window and 500 ms low-current window
`define CSV_DISCH_MS 10'h3e8
`define CSV_LOWI_MS 10'h1f4
// debounce: input must hold this many cycles before it is believed
`define CSV_DEB_CYCLES 3'h4

// ----------------------------------------------------------------------
// current target, in eighths of the programmed value
// ----------------------------------------------------------------------
`define CSV_SS_FULL 4'h8
`define CSV_SS_FIRST 4'h1
`define CSV_REDUCED 4'h1
`define CSV_CUR_ZERO 4'h0

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define CSV_OFS_CTRL 4'h0
`define CSV_OFS_LIMIT 4'h4
`define CSV_OFS_STATUS 4'h8
`define CSV_OFS_SAFE_CNT 4'hc
`define CSV_CTRL_RST 32'h0000_0003
`define CSV_LIMIT_RST 32'h0089_5440
`define CSV_CTRL_SW_EN 0
`define CSV_CTRL_TMR_EN 1

`endif

/* csv_pkg.sv */
package csv_pkg;

  // one-hot supervisor states
  typedef enum logic [5:0] {
    ST_OFF    = 6'h01,
    ST_DISCH  = 6'h02,
    ST_LOWI   = 6'h04,
    ST_CHARGE = 6'h08,
    ST_DONE   = 6'h10,
    ST_FAULT  = 6'h20
  } csv_state_t;

  // comparator indications from the analog stage, high when true
  typedef struct packed {
    logic battery_overvoltage_flag;
    logic over_current;
    logic die_above_shutdown;
    logic die_below_restart;
    logic past_cold_fault_threshold;
    logic in_cool_zone;
    logic in_warm_zone;
    logic past_hot_fault_threshold;
    logic bat_above_recharge;
    logic bat_below_low_battery_threshold;
    logic supply_undervoltage_lockout;
    logic input_overvoltage;
    logic sleep_mode;
    logic charge_terminated;
  } csv_cmp_t;

  // drive toward the power stage
  typedef struct packed {
    logic hs_gate_en;
    logic ls_gate_en;
    logic sense_node_pos_sink;
    logic sense_node_neg_sink;
    logic fault_probe_current;
    logic low_current_mode;
    logic gate_bias_en;
    logic [3:0] cur_eighths;
  } csv_drv_t;

  // open-drain status pins
  typedef struct packed {
    logic supply_good_output;
    logic status_line_a;
    logic status_line_b;
  } csv_od_t;

endpackage

/* csv_top.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "csv_consts.svh"

// Summary of operation
// - block high side at or above 105%
// - positive sense sink on only in charge and low-current states
// - overvoltage pauses safety timer, keeps count
// - overcurrent above 160% gates high side off
// - thermal shutdown 145C, release below 130C
// - thermal shutdown pauses safety timer
// - start charge only inside temperature window
// - outside window suspend and pause timer
// - cool or warm zone cuts current to eighth
// - suspension holds both switches off
// - high-side fault clears below recharge, redetects
// - charge enable low clears latched fault
// - low-side fault sources probe until above recharge
// - supply good on when supply valid
// - charge only while charge enable high
// - enable falling edge resets timers and faults
// - two status lines encode charge state
// - detect discharge, low level within 1 s
// - recharge level within 500 ms means absent
// - window expiry means battery present, charge
// - soft-start eight levels, seven steps of 1.6 ms
// - undervoltage lockout removes gate bias
module csv_top #(
  parameter int MS_CYCLES = `CSV_MS_NS / `CSV_CLK_NS,
  parameter int SS_CYCLES = `CSV_SS_STEP_NS / `CSV_CLK_NS
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // analog comparators and charge enable
  input wire csv_pkg::csv_cmp_t CMP_IN,
  input wire logic CHG_EN,
  // power stage drive
  output csv_pkg::csv_drv_t DRV_OUT,
  // open-drain status pins
  input wire csv_pkg::csv_od_t OD_IN,
  output csv_pkg::csv_od_t OD_OUT,
  output csv_pkg::csv_od_t OD_OE
);
  import csv_pkg::*;

  localparam int NCMP = $bits(csv_cmp_t);

  // --------------------------------------------------------------------
  // input conditioning
  // --------------------------------------------------------------------
  logic [NCMP-1:0] cmp_deb;
  csv_cmp_t deb;
  assign deb = csv_cmp_t'(cmp_deb);

  // a comparator chatters near its trip point; only a level that holds
  // for the debounce time reaches the state logic
  for (genvar gi = 0; gi < NCMP; gi++) begin : g_deb
    logic s1_r;
    logic s2_r;
    logic deb_r;
    logic [2:0] cnt_r;
    always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
        s1_r <= 1'h0;
        s2_r <= 1'h0;
        deb_r <= 1'h0;
        cnt_r <= 3'h0;
      end else begin
        s1_r <= CMP_IN[gi];
        s2_r <= s1_r;
        if (s2_r == deb_r) begin
          cnt_r <= 3'h0;
        end else if (cnt_r == `CSV_DEB_CYCLES - 3'h1) begin
          deb_r <= s2_r;
          cnt_r <= 3'h0;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
    assign cmp_deb[gi] = deb_r;
  end

  // --------------------------------------------------------------------
  // registers and derived conditions
  // --------------------------------------------------------------------
  csv_state_t st_r, st_nxt;
  logic [31:0] ctrl_r, limit_r, safe_ms_r;
  logic [19:0] ms_cnt_r, ss_cnt_r;
  logic [9:0] det_ms_r;
  logic [3:0] ss_step_r, cur_nxt;
  logic ce_q_r, die_overtemp_shutdown_r, fault_hi_r, wait_r;
  logic [31:0] rdata_r;
  csv_drv_t drv_r;
  csv_od_t od_oe_r, od_out_r;

  logic supply_ok, chg_req, ce_fall, temp_out, pause, suspend, reduced;
  logic ms_tick, safe_exp, det_done, active, sw_ok;

  assign supply_ok = !(deb.supply_undervoltage_lockout |
                       deb.input_overvoltage | deb.sleep_mode);
  assign chg_req = CHG_EN & ctrl_r[`CSV_CTRL_SW_EN];
  assign ce_fall = ce_q_r & !CHG_EN;
  assign temp_out = deb.past_cold_fault_threshold |
                    deb.past_hot_fault_threshold;
  assign suspend = die_overtemp_shutdown_r | temp_out;
  assign pause = suspend | deb.battery_overvoltage_flag;
  assign reduced = deb.in_cool_zone | deb.in_warm_zone;
  assign ms_tick = (ms_cnt_r == 20'(MS_CYCLES - 1));
  assign safe_exp = ctrl_r[`CSV_CTRL_TMR_EN] && (safe_ms_r >= limit_r);
  assign det_done = (st_r == ST_DISCH) ? (det_ms_r >= `CSV_DISCH_MS)
                                      : (det_ms_r >= `CSV_LOWI_MS);
  assign active = (st_r == ST_CHARGE) || (st_r == ST_LOWI);
  assign sw_ok = active && !suspend;

  // --------------------------------------------------------------------
  // supervisor state machine
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!supply_ok || !chg_req) begin
      st_nxt = ST_OFF;
    end else begin
      case (st_r)
        ST_OFF: st_nxt = ST_DISCH;
        ST_DISCH: begin
          if (deb.bat_below_low_battery_threshold) begin
            st_nxt = ST_LOWI;
          end else if (det_done && !temp_out) begin
            st_nxt = ST_CHARGE;
          end
        end
        ST_LOWI: begin
          if (deb.bat_above_recharge) begin
            st_nxt = ST_DISCH;
          end else if (det_done && !temp_out) begin
            st_nxt = ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (safe_exp) begin
            st_nxt = ST_FAULT;
          end else if (deb.charge_terminated && !pause) begin
            st_nxt = ST_DONE;
          end
        end
        ST_DONE: begin
          if (!deb.bat_above_recharge) begin
            st_nxt = ST_DISCH;
          end
        end
        ST_FAULT: begin
          if (fault_hi_r && !deb.bat_above_recharge) begin
            st_nxt = ST_DISCH;
          end
        end
        default: st_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_r <= ST_OFF;
      ce_q_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      ce_q_r <= CHG_EN;
    end
  end

  // --------------------------------------------------------------------
  // timers
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || ms_tick) begin
      ms_cnt_r <= 20'h0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 20'h1;
    end
  end

  // detection window, saturates so a late temperature return still starts
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || st_nxt != st_r || !(st_r == ST_DISCH ||
        st_r == ST_LOWI)) begin
      det_ms_r <= 10'h0;
    end else if (ms_tick && !det_done) begin
      det_ms_r <= det_ms_r + 10'h1;
    end
  end

  // safety timer: cleared on a new cycle or enable drop, frozen on pause
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !chg_req || st_r == ST_OFF) begin
      safe_ms_r <= 32'h0;
    end else if (st_nxt == ST_CHARGE && st_r != ST_CHARGE) begin
      safe_ms_r <= 32'h0;
    end else if (st_r == ST_CHARGE && ms_tick && !pause &&
                 ctrl_r[`CSV_CTRL_TMR_EN]) begin
      safe_ms_r <= safe_ms_r + 32'h1;
    end
  end

  // fault flavour: set when the battery sits above recharge
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !chg_req || st_r == ST_OFF) begin
      fault_hi_r <= 1'h0;
    end else if (st_r == ST_CHARGE && st_nxt == ST_FAULT) begin
      fault_hi_r <= deb.bat_above_recharge;
    end else if (st_r == ST_FAULT && deb.bat_above_recharge) begin
      fault_hi_r <= 1'h1;
    end
  end

  // thermal shutdown with hysteresis; the hot indication wins
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      die_overtemp_shutdown_r <= 1'h0;
    end else if (deb.die_above_shutdown) begin
      die_overtemp_shutdown_r <= 1'h1;
    end else if (deb.die_below_restart) begin
      die_overtemp_shutdown_r <= 1'h0;
    end
  end

  // soft-start: restarts from the first step after every suspension
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || st_r != ST_CHARGE || suspend) begin
      ss_step_r <= `CSV_CUR_ZERO;
      ss_cnt_r <= 20'h0;
    end else if (ss_step_r == `CSV_CUR_ZERO) begin
      ss_step_r <= `CSV_SS_FIRST;
    end else if (ss_step_r != `CSV_SS_FULL) begin
      if (ss_cnt_r == 20'(SS_CYCLES - 1)) begin
        ss_cnt_r <= 20'h0;
        ss_step_r <= ss_step_r + 4'h1;
      end else begin
        ss_cnt_r <= ss_cnt_r + 20'h1;
      end
    end
  end

  always_comb begin
    cur_nxt = ss_step_r;
    if (st_r != ST_CHARGE) begin
      cur_nxt = `CSV_CUR_ZERO;
    end else if (reduced && ss_step_r != `CSV_CUR_ZERO) begin
      cur_nxt = `CSV_REDUCED;
    end
  end

  // --------------------------------------------------------------------
  // output drive
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      drv_r <= '0;
    end else begin
      drv_r.hs_gate_en <= sw_ok && !deb.battery_overvoltage_flag &&
                          !deb.over_current;
      drv_r.ls_gate_en <= sw_ok;
      drv_r.sense_node_pos_sink <= active;
      drv_r.sense_node_neg_sink <= (st_r == ST_DISCH);
      drv_r.fault_probe_current <= (st_r == ST_FAULT) &&
                                   !fault_hi_r;
      drv_r.low_current_mode <= (st_r == ST_LOWI);
      drv_r.gate_bias_en <= !deb.supply_undervoltage_lockout;
      drv_r.cur_eighths <= cur_nxt;
    end
  end

  // open drain: enable high pulls the pin low, i.e. the line is on
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      od_oe_r <= '0;
      od_out_r <= '0;
    end else begin
      od_out_r <= '0;
      od_oe_r.supply_good_output <= supply_ok;
      od_oe_r.status_line_a <= (st_r == ST_CHARGE) && !pause;
      od_oe_r.status_line_b <= (st_r == ST_DONE);
    end
  end

  // --------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------
  // one wait cycle on every access keeps read data a clean flop output
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      wait_r <= 1'h1;
    end else if ((AVS_READ || AVS_WRITE) && wait_r) begin
      wait_r <= 1'h0;
    end else begin
      wait_r <= 1'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_r <= `CSV_CTRL_RST;
      limit_r <= `CSV_LIMIT_RST;
    end else if (AVS_WRITE && !wait_r) begin
      for (int b = 0; b < 4; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          if (AVS_ADDRESS == `CSV_OFS_CTRL) begin
            ctrl_r[8*b +: 8] <= AVS_WRITEDATA[8*b +: 8];
          end else if (AVS_ADDRESS == `CSV_OFS_LIMIT) begin
            limit_r[8*b +: 8] <= AVS_WRITEDATA[8*b +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0;
    end else if (AVS_READ && wait_r) begin
      if (AVS_ADDRESS == `CSV_OFS_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (AVS_ADDRESS == `CSV_OFS_LIMIT) begin
        rdata_r <= limit_r;
      end else if (AVS_ADDRESS == `CSV_OFS_STATUS) begin
        rdata_r <= {15'h0, OD_IN, drv_r.cur_eighths, supply_ok,
                    fault_hi_r, temp_out, die_overtemp_shutdown_r, st_r};
      end else if (AVS_ADDRESS == `CSV_OFS_SAFE_CNT) begin
        rdata_r <= safe_ms_r;
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end

  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign DRV_OUT = drv_r;
  assign OD_OUT = od_out_r;
  assign OD_OE = od_oe_r;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_enter_detect;
    st_r == ST_OFF ##1 st_r == ST_DISCH;
  endsequence

  sequence s_ce_drop;
    ce_fall ##1 st_r == ST_OFF;
  endsequence

  chk_ovp_blocks_hs: assert property (
    deb.battery_overvoltage_flag |=> !DRV_OUT.hs_gate_en)
    else $error("high side on during overvoltage");
  chk_pos_sink_idle: assert property (
    !active |=> !DRV_OUT.sense_node_pos_sink)
    else $error("positive sink on while not charging");
  chk_timer_paused: assert property (
    (st_r == ST_CHARGE && pause && st_nxt == ST_CHARGE)
    |=> $stable(safe_ms_r))
    else $error("safety timer moved while paused");
  chk_ocp_gate: assert property (
    deb.over_current |=> !DRV_OUT.hs_gate_en)
    else $error("high side on during overcurrent");
  chk_die_overtemp_shutdown_hold: assert property (
    die_overtemp_shutdown_r && !deb.die_below_restart |=> die_overtemp_shutdown_r)
    else $error("thermal shutdown released early");
  chk_susp_both_off: assert property (
    suspend |=> !DRV_OUT.hs_gate_en && !DRV_OUT.ls_gate_en)
    else $error("switch on during suspension");
  chk_cool_warm_cut: assert property (
    st_r == ST_CHARGE && reduced && ss_step_r != `CSV_CUR_ZERO
    |=> DRV_OUT.cur_eighths == `CSV_REDUCED)
    else $error("current not reduced in cool or warm zone");
  chk_fault_redetect: assert property (
    st_r == ST_FAULT && fault_hi_r && !deb.bat_above_recharge &&
    supply_ok && chg_req |=> st_r == ST_DISCH)
    else $error("timer fault did not clear below recharge");
  chk_fault_probe: assert property (
    st_r == ST_FAULT && !fault_hi_r |=> DRV_OUT.fault_probe_current)
    else $error("probe current missing in low fault");
  chk_supply_good: assert property (
    supply_ok |=> OD_OE.supply_good_output)
    else $error("supply good not on");
  chk_ce_fall_clear: assert property (
    s_ce_drop |-> safe_ms_r == 32'h0 && !fault_hi_r)
    else $error("enable drop did not clear timers and faults");
  chk_done_status: assert property (
    st_r == ST_DONE |=> OD_OE.status_line_b && !OD_OE.status_line_a)
    else $error("status lines wrong on charge complete");
  chk_detect_sink: assert property (
    s_enter_detect |=> DRV_OUT.sense_node_neg_sink)
    else $error("negative sink off in discharge window");
  chk_absent_restart: assert property (
    st_r == ST_LOWI && deb.bat_above_recharge && supply_ok && chg_req
    |=> st_r == ST_DISCH)
    else $error("absent battery did not restart detection");
  chk_present_charge: assert property (
    st_r == ST_DISCH && det_ms_r == `CSV_DISCH_MS && supply_ok &&
    chg_req && !deb.bat_below_low_battery_threshold && !temp_out
    |=> st_r == ST_CHARGE)
    else $error("expired discharge window did not start charge");
  chk_ss_first_step: assert property (
    st_r == ST_CHARGE && !suspend && ss_step_r == `CSV_CUR_ZERO
    |=> ss_step_r == `CSV_SS_FIRST)
    else $error("soft-start did not begin at first step");
  chk_supply_undervoltage_lockout_bias: assert property (
    deb.supply_undervoltage_lockout |=> !DRV_OUT.gate_bias_en)
    else $error("gate bias present in lockout");

endmodule

/* csv_pack_model.sv */
`timescale 1ns/10ps
// ---
// battery pack, comparators and status pull-ups
// ---
module csv_pack_model (
  // clock and scenario knobs
  input wire logic clk,
  input wire logic present,
  input wire csv_pkg::csv_cmp_t env,
  // device side
  input wire csv_pkg::csv_drv_t drv,
  input wire csv_pkg::csv_od_t od_oe,
  output csv_pkg::csv_cmp_t cmp,
  output csv_pkg::csv_od_t od_pin
);
  import csv_pkg::*;
  logic [5:0] sag_r;
  // an empty terminal is only the output capacitor: it sags fast under
  // the sink and reads above recharge whenever low-current mode is on
  always_ff @(posedge clk) begin
    if (present || !drv.sense_node_neg_sink) begin
      sag_r <= 6'h00;
    end else if (sag_r != 6'h3f) begin
      sag_r <= sag_r + 6'h01;
    end
  end
  always_comb begin
    cmp = env;
    if (!present) begin
      cmp.bat_below_low_battery_threshold = (sag_r > 6'h10);
      cmp.bat_above_recharge = drv.low_current_mode;
    end
  end
  // pull-ups: a pin is low only while its transistor is on
  assign od_pin = ~od_oe;
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import csv_pkg::*;
  localparam int MSC = 10;
  localparam int SSC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hf;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic waitreq;
  csv_cmp_t env = 14'h0000;
  csv_cmp_t cmp;
  logic present = 1'b1;
  logic chg_en = 1'b0;
  csv_drv_t drv;
  csv_od_t od_pin;
  csv_od_t od_out;
  csv_od_t od_oe;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] q;
  logic [31:0] d;
  logic [31:0] lim;
  logic [15:0] v;
  int n;

  always #2 clk = ~clk;

  csv_top #(.MS_CYCLES(MSC), .SS_CYCLES(SSC)) dut (
    .REF_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .CMP_IN(cmp),
    .CHG_EN(chg_en), .DRV_OUT(drv), .OD_IN(od_pin), .OD_OUT(od_out),
    .OD_OE(od_oe)
  );

  csv_pack_model pack (
    .clk(clk), .present(present), .env(env), .drv(drv), .od_oe(od_oe),
    .cmp(cmp), .od_pin(od_pin)
  );

  // ---
  // helpers
  // ---
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b,
                     input logic [31:0] dd, output logic [31:0] r);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    be <= b;
    wdata <= dd;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_state(input logic [5:0] st);
    logic [31:0] r;
    int k;
    k = 0;
    r = 32'h0000_0000;
    while (r[5:0] !== st && k < 4000) begin
      bus(1'b0, 4'h8, 4'hf, 32'h0000_0000, r);
      k++;
    end
    check(r[5:0], st);
  endtask

  task automatic wait_bit(input int idx, input logic val, input int lim_c);
    int k;
    k = 0;
    while (drv[idx] !== val && k < lim_c) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic frozen();
    logic [31:0] a;
    logic [31:0] b;
    bus(1'b0, 4'hc, 4'hf, 32'h0000_0000, a);
    tick(3 * MSC);
    bus(1'b0, 4'hc, 4'hf, 32'h0000_0000, b);
    check(b, a);
  endtask

  // n0 counts edges to the first step; the step walk is checked here
  task automatic ramp(output int n0);
    int k;
    n0 = 0;
    while (drv.cur_eighths !== 4'h1 && n0 < 12000) begin
      @(posedge clk);
      n0++;
    end
    k = 0;
    while (drv.cur_eighths !== 4'h8 && k < 100) begin
      @(posedge clk);
      k++;
    end
    check(32'(k), 32'(7 * SSC));
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ---
  // scenarios
  // ---
  initial begin
    v = 16'h9a9c;
    lim = 32'h0089_5440;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 4'hf, 32'h0000_0000, q);
    check(q, 32'h0000_0003);
    bus(1'b0, 4'h4, 4'hf, 32'h0000_0000, q);
    check(q, lim);
    for (int i = 0; i < 3; i++) begin
      v = lfsr(v);
      d = {v, lfsr(v)};
      bus(1'b1, 4'h4, v[3:0], d, q);
      for (int b = 0; b < 4; b++) begin
        if (v[b]) lim[8*b +: 8] = d[8*b +: 8];
      end
      bus(1'b1, {v[3:2], 2'b10}, 4'hf, ~d, q);
      bus(1'b0, {v[3:2], 2'b10}, 4'hf, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      bus(1'b0, 4'h4, 4'hf, 32'h0000_0000, q);
      check(q, lim);
    end
    bus(1'b1, 4'h4, 4'hf, 32'h0000_00c8, q);
    check(od_out, 3'h0);
    check(od_oe.supply_good_output, 1'b1);
    bus(1'b0, 4'h8, 4'hf, 32'h0000_0000, q);
    check(q[16:14], 3'h3);
    check(q[5:0], ST_OFF);
    for (int i = 1; i < 4; i++) begin
      env <= csv_cmp_t'(14'h0001 << i);
      tick(12);
      check(od_oe.supply_good_output, 1'b0);
      if (i == 3) check(drv.gate_bias_en, 1'b0);
    end
    env <= 14'h0000;
    present <= 1'b0;
    tick(12);
    chg_en <= 1'b1;
    tick(3);
    check(drv.sense_node_neg_sink, 1'b1);
    wait_bit(5, 1'b1, 300);
    check(drv[7:5], 3'h1);
    wait_bit(7, 1'b1, 300);
    check(drv[10:5], 6'h04);
    present <= 1'b1;
    chg_en <= 1'b0;
    tick(3);
    chg_en <= 1'b1;
    ramp(n);
    // the window opens on a free-running ms tick: 999 to 1000 ms long
    check(n >= 999 * MSC + 6 && n <= 1000 * MSC + 5, 1'b1);
    check(drv[8:7], 2'h2);
    check(od_oe[1:0], 2'h2);
    env <= 14'h2000;
    tick(12);
    check(drv.hs_gate_en, 1'b0);
    check(od_oe[1:0], 2'h0);
    frozen();
    env <= 14'h1000;
    tick(12);
    check({drv.hs_gate_en, drv.cur_eighths}, 5'h08);
    env <= 14'h0000;
    tick(12);
    check(drv.hs_gate_en, 1'b1);
    // a three-cycle overvoltage glitch is shorter than the debounce time
    env <= 14'h2000;
    tick(3);
    env <= 14'h0000;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      n += int'(drv.hs_gate_en);
    end
    check(32'(n), 32'h0000_000c);
    env <= 14'h0800;
    tick(12);
    check({drv[10:9], drv.cur_eighths}, 6'h00);
    frozen();
    env <= 14'h0000;
    tick(12);
    check(drv.hs_gate_en, 1'b0);
    env <= 14'h0400;
    ramp(n);
    for (int i = 7; i < 9; i++) begin
      env <= csv_cmp_t'(14'h0001 << i);
      tick(12);
      check(drv.cur_eighths, 4'h1);
    end
    env <= 14'h0040;
    tick(12);
    check(drv[10:9], 2'h0);
    frozen();
    env <= 14'h0000;
    ramp(n);
    wait_state(ST_FAULT);
    tick(2);
    check(drv[10:6], 5'h01);
    env <= 14'h0020;
    tick(12);
    check(drv.fault_probe_current, 1'b0);
    env <= 14'h0000;
    wait_state(ST_DISCH);
    env <= 14'h0020;
    ramp(n);
    wait_state(ST_FAULT);
    check(od_oe[1:0], 2'h0);
    chg_en <= 1'b0;
    tick(3);
    bus(1'b0, 4'h8, 4'hf, 32'h0000_0000, q);
    check(q[5:0], ST_OFF);
    bus(1'b0, 4'hc, 4'hf, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    env <= 14'h0220;
    chg_en <= 1'b1;
    tick(1000 * MSC + 100);
    bus(1'b0, 4'h8, 4'hf, 32'h0000_0000, q);
    check(q[3], 1'b0);
    env <= 14'h0020;
    wait_state(ST_CHARGE);
    env <= 14'h0021;
    wait_state(ST_DONE);
    tick(2);
    check(od_oe[1:0], 2'h1);
    give_verdict();
  end
endmodule
